// ===== src/dmm_data_memory.sv
// Function
// - No external memory; internal stores only.
// - Lower RAM, upper RAM, SFRs, data store.
// - Upper half: indirect RAM, direct SFR.
// - Lower RAM same for direct, indirect.
// - Four register banks chosen by status bits.
// - Bytes 20H-2FH hold bits 00H-7FH.
// - Stack anywhere in RAM, 256 deep.
// - Stack pointer resets 07H, pre-increments.
// - Code pointer: two bytes or one word.
// - Status word at D0H, reset 00H.
// - Power control at 87H, reset 00H.
// - Unoccupied SFR addresses hold no storage.
// - SFRs ending 0H or 8H bit addressable.
// - Read-only silicon revision identifier register.
// - Calibration loads factory values, stays writable.
// - Data store reached through SFR registers.
`timescale 1ns/1ps
module dmm_data_memory (
	input wire logic clock_i, // Core clock.
	input wire logic nrst_i, // Asynchronous reset, active low.
	input wire logic ce_i, // Clock enable; low freezes all state.
	input wire dmm_pkg::dmm_req_t req_i, // Direct, indirect, bit or bank access.
	input wire logic push_i, // Push stack_wdata_i.
	input wire logic pop_i, // Pop a byte onto rdata_o.
	input wire logic [7:0] stack_wdata_i, // Byte to push.
	input wire logic accum_we_i, // Arithmetic unit writes accumulator.
	input wire logic [7:0] accum_wdata_i, // New accumulator value.
	input wire dmm_pkg::dmm_flags_t flags_i, // Carry, aux carry, overflow.
	input wire logic cptr_we_i, // Load code pointer as a word.
	input wire logic [15:0] cptr_wdata_i, // Code pointer word.
	output logic [7:0] rdata_o, // Read answer.
	output logic rvalid_o, // Read answer valid, one cycle.
	output logic [7:0] accumulator_o, // Accumulator.
	output logic [7:0] program_status_word_o, // Status word.
	output logic [7:0] stack_top_pointer_o, // Stack pointer.
	output logic [7:0] power_control_o, // Power control.
	output logic [15:0] code_pointer_word_o, // Code pointer word.
	output logic [15:0] calibration_o // Calibration coefficients.
);
	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	// Only on-chip stores exist; there is no external memory port.
	logic [7:0] ram_q [0:dmm_pkg::RAM_BYTES-1]; // Lower and upper RAM.
	logic [7:0] nv_q [0:dmm_pkg::NV_BYTES-1]; // Nonvolatile data store.
	logic [7:0] accum_q, accum_d; // Accumulator.
	logic [7:0] b_q, b_d; // Scratch register.
	logic [7:0] stk_q, stk_d; // Stack pointer.
	logic [7:0] cplo_q, cplo_d; // Code pointer low.
	logic [7:0] cphi_q, cphi_d; // Code pointer high.
	logic [7:0] pwr_q, pwr_d; // Power control.
	logic [7:0] stat_q, stat_d; // Status word.
	logic [7:0] call_q, call_d; // Calibration low.
	logic [7:0] calh_q, calh_d; // Calibration high.
	logic [7:0] nvdat_q, nvdat_d; // Data store data.
	logic [9:0] nvadr_q, nvadr_d; // Data store address.
	logic [7:0] rd_q, rd_d; // Read answer.
	logic rv_q, rv_d; // Read answer valid.
	logic ram_we; // RAM write strobe.
	logic [7:0] ram_wa; // RAM write address.
	logic [7:0] ram_wd; // RAM write data.
	logic nv_we; // Data store program strobe.
	logic tgt_sfr; // Access lands in SFR space.
	logic [7:0] tgt_a; // Byte address of the access.
	logic [7:0] cur; // Current byte at the target.
	logic [7:0] wval; // Byte to store.
	logic [7:0] sfr_rd; // SFR read mux.

	// ----------------------------------------------------------------
	// Target decode.
	// ----------------------------------------------------------------
	// Bit mode above 7FH can only form addresses ending in 0H or 8H,
	// so the bit space itself rules out other SFRs.
	always_comb begin
		tgt_sfr = 1'b0;
		tgt_a = req_i.addr;
		unique case (req_i.mode)
			dmm_pkg::DMM_DIRECT: begin
				tgt_sfr = req_i.addr[7];
			end
			dmm_pkg::DMM_INDIRECT: begin
				tgt_sfr = 1'b0;
			end
			dmm_pkg::DMM_BIT: begin
				tgt_sfr = req_i.addr[7];
				if (req_i.addr[7]) begin
					tgt_a = {req_i.addr[7:3], 3'b000};
				end else begin
					// Sixteen bytes from 20H hold eight bits each; no spare bit between.
					tgt_a = {dmm_pkg::BIT_BASE_HI, req_i.addr[6:3]};
				end
			end
			dmm_pkg::DMM_WREG: begin
				tgt_a = {3'b000, stat_q[dmm_pkg::STATUS_BANK_HI:dmm_pkg::STATUS_BANK_LO],
					req_i.addr[2:0]};
			end
		endcase
	end

	// ----------------------------------------------------------------
	// SFR read mux.
	// ----------------------------------------------------------------
	always_comb begin
		unique case (tgt_a)
			dmm_pkg::SFR_ACCUM: sfr_rd = accum_q;
			dmm_pkg::SFR_B: sfr_rd = b_q;
			dmm_pkg::SFR_STACK_TOP: sfr_rd = stk_q;
			dmm_pkg::SFR_CPTR_LO: sfr_rd = cplo_q;
			dmm_pkg::SFR_CPTR_HI: sfr_rd = cphi_q;
			dmm_pkg::SFR_POWER: sfr_rd = pwr_q;
			dmm_pkg::SFR_STATUS: sfr_rd = stat_q;
			dmm_pkg::SFR_REV: sfr_rd = dmm_pkg::REV_ID;
			dmm_pkg::SFR_CALL: sfr_rd = call_q;
			dmm_pkg::SFR_CALH: sfr_rd = calh_q;
			dmm_pkg::SFR_NVDAT: sfr_rd = nvdat_q;
			dmm_pkg::SFR_NVADL: sfr_rd = nvadr_q[7:0];
			dmm_pkg::SFR_NVADH: sfr_rd = {6'h00, nvadr_q[9:8]};
			// Nothing stands behind unoccupied addresses; they read zero.
			default: sfr_rd = 8'h00;
		endcase
		cur = tgt_sfr ? sfr_rd : ram_q[tgt_a];
		wval = req_i.wdata;
		if (req_i.mode == dmm_pkg::DMM_BIT) begin
			wval = cur;
			wval[req_i.addr[2:0]] = req_i.wdata[0];
		end
	end

	// ----------------------------------------------------------------
	// Next state. Priority: access, then push, then pop; the
	// arithmetic port and the flag port win over an SFR write.
	// ----------------------------------------------------------------
	always_comb begin
		accum_d = accum_q;
		b_d = b_q;
		stk_d = stk_q;
		cplo_d = cplo_q;
		cphi_d = cphi_q;
		pwr_d = pwr_q;
		stat_d = stat_q;
		call_d = call_q;
		calh_d = calh_q;
		nvdat_d = nvdat_q;
		nvadr_d = nvadr_q;
		rd_d = 8'h00;
		rv_d = 1'b0;
		ram_we = 1'b0;
		ram_wa = tgt_a;
		ram_wd = wval;
		nv_we = 1'b0;
		if (req_i.valid && !req_i.we) begin
			rv_d = 1'b1;
			rd_d = (req_i.mode == dmm_pkg::DMM_BIT) ? {7'h00, cur[req_i.addr[2:0]]} : cur;
		end else if (req_i.valid && !tgt_sfr) begin
			ram_we = 1'b1;
		end else if (req_i.valid) begin
			unique case (tgt_a)
				dmm_pkg::SFR_ACCUM: accum_d = wval;
				dmm_pkg::SFR_B: b_d = wval;
				dmm_pkg::SFR_STACK_TOP: stk_d = wval;
				dmm_pkg::SFR_CPTR_LO: cplo_d = wval;
				dmm_pkg::SFR_CPTR_HI: cphi_d = wval;
				dmm_pkg::SFR_POWER: pwr_d = wval & dmm_pkg::POWER_WMASK;
				dmm_pkg::SFR_STATUS: stat_d = wval;
				dmm_pkg::SFR_CALL: call_d = wval;
				dmm_pkg::SFR_CALH: calh_d = wval;
				dmm_pkg::SFR_NVDAT: nvdat_d = wval;
				dmm_pkg::SFR_NVADL: nvadr_d[7:0] = wval;
				dmm_pkg::SFR_NVADH: nvadr_d[9:8] = wval[1:0];
				dmm_pkg::SFR_NVCTL: begin
					// Commands beyond the last store byte are dropped.
					if (nvadr_q <= dmm_pkg::NV_LAST) begin
						if (wval == dmm_pkg::NV_CMD_READ) begin
							nvdat_d = nv_q[nvadr_q];
						end
						nv_we = (wval == dmm_pkg::NV_CMD_WRITE);
					end
				end
				// Writes to the revision and unoccupied places vanish.
				default: ;
			endcase
		end else if (push_i) begin
			// Pre-increment, then store; the 8-bit pointer spans all RAM.
			stk_d = stk_q + 8'h01;
			ram_we = 1'b1;
			ram_wa = stk_q + 8'h01;
			ram_wd = stack_wdata_i;
		end else if (pop_i) begin
			rv_d = 1'b1;
			rd_d = ram_q[stk_q];
			stk_d = stk_q - 8'h01;
		end
		if (cptr_we_i) begin
			{cphi_d, cplo_d} = cptr_wdata_i;
		end
		if (accum_we_i) begin
			accum_d = accum_wdata_i;
		end
		if (flags_i.we) begin
			stat_d[dmm_pkg::STATUS_CARRY] = flags_i.carry;
			stat_d[dmm_pkg::STATUS_AUX] = flags_i.aux;
			stat_d[dmm_pkg::STATUS_EXCESS] = flags_i.excess;
		end
		// Parity follows the accumulator; software cannot hold it.
		stat_d[dmm_pkg::STATUS_PARITY] = ^accum_d;
	end

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			accum_q <= 8'h00;
			b_q <= 8'h00;
			stk_q <= dmm_pkg::STACK_TOP_RST;
			cplo_q <= 8'h00;
			cphi_q <= 8'h00;
			pwr_q <= dmm_pkg::POWER_RST;
			stat_q <= dmm_pkg::STATUS_RST;
			call_q <= dmm_pkg::CAL_FACT_LO;
			calh_q <= dmm_pkg::CAL_FACT_HI;
			nvdat_q <= 8'h00;
			nvadr_q <= 10'h000;
			rd_q <= 8'h00;
			rv_q <= 1'b0;
		end else if (ce_i) begin
			accum_q <= accum_d;
			b_q <= b_d;
			stk_q <= stk_d;
			cplo_q <= cplo_d;
			cphi_q <= cphi_d;
			pwr_q <= pwr_d;
			stat_q <= stat_d;
			call_q <= call_d;
			calh_q <= calh_d;
			nvdat_q <= nvdat_d;
			nvadr_q <= nvadr_d;
			rd_q <= rd_d;
			rv_q <= rv_d;
		end
	end

	// The arrays carry data only, so they are left out of reset.
	always_ff @(posedge clock_i) begin
		if (ce_i && ram_we) begin
			ram_q[ram_wa] <= ram_wd;
		end
		if (ce_i && nv_we) begin
			nv_q[nvadr_q] <= nvdat_q;
		end
	end

	assign rdata_o = rd_q;
	assign rvalid_o = rv_q;
	assign accumulator_o = accum_q;
	assign program_status_word_o = stat_q;
	assign stack_top_pointer_o = stk_q;
	assign power_control_o = pwr_q;
	assign code_pointer_word_o = {cphi_q, cplo_q};
	assign calibration_o = {calh_q, call_q};

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	logic wr_go;
	assign wr_go = ce_i && req_i.valid && req_i.we;

	push_incr_a: assert property (ce_i && push_i && !req_i.valid |=>
		stk_q == $past(stk_q) + 8'h01) else $error("push did not pre-increment");
	push_store_a: assert property (ce_i && push_i && !req_i.valid |=>
		ram_q[stk_q] == $past(stack_wdata_i)) else $error("pushed byte not stored");
	// A pop answers with the byte at the old top, one cycle later.
	pop_read_a: assert property (ce_i && pop_i && !push_i && !req_i.valid |=>
		rvalid_o && rdata_o == ram_q[$past(stk_q)]) else $error("popped byte wrong");
	accum_parity_a: assert property (stat_q[dmm_pkg::STATUS_PARITY] == ^accum_q)
		else $error("parity does not follow accumulator");
	ind_upper_a: assert property (wr_go && req_i.mode == dmm_pkg::DMM_INDIRECT
		&& req_i.addr == dmm_pkg::SFR_B |=> $stable(b_q)) else $error("indirect hit SFR");
	direct_sfr_a: assert property (wr_go && req_i.mode == dmm_pkg::DMM_DIRECT
		&& req_i.addr == dmm_pkg::SFR_B |=> b_q == $past(req_i.wdata))
		else $error("direct SFR write lost");
	bank_wr_a: assert property (wr_go && req_i.mode == dmm_pkg::DMM_WREG |=>
		ram_q[{3'b000, $past(stat_q[4:3]), $past(req_i.addr[2:0])}] == $past(req_i.wdata))
		else $error("bank register write misplaced");
	bit_map_a: assert property (wr_go && req_i.mode == dmm_pkg::DMM_BIT && !req_i.addr[7]
		|=> ram_q[{4'h2, $past(req_i.addr[6:3])}][$past(req_i.addr[2:0])]
		== $past(req_i.wdata[0])) else $error("bit write misplaced");
	power_rsv_a: assert property (pwr_q[dmm_pkg::POWER_RSV] == 1'b0)
		else $error("reserved power bit set");
	cptr_word_a: assert property (ce_i && cptr_we_i |=>
		code_pointer_word_o == $past(cptr_wdata_i)) else $error("code pointer word not loaded");
	rev_ro_a: assert property (ce_i && req_i.valid && !req_i.we && req_i.addr ==
		dmm_pkg::SFR_REV && req_i.mode == dmm_pkg::DMM_DIRECT |=> rvalid_o
		&& rdata_o == dmm_pkg::REV_ID) else $error("revision read wrong");

	push_pop_c: cover property (ce_i && push_i ##1 ce_i && pop_i);
	bit_sfr_c: cover property (wr_go && req_i.mode == dmm_pkg::DMM_BIT && req_i.addr[7]);
	nv_cmd_c: cover property (nv_we);
	bank_reg_c: cover property (wr_go && req_i.mode == dmm_pkg::DMM_WREG);
endmodule

// ===== include/dmm_pkg.sv
package dmm_pkg;
	// ----------------------------------------------------------------
	// Special function addresses.
	// ----------------------------------------------------------------
	localparam logic [7:0] SFR_STACK_TOP = 8'h81; // Stack pointer.
	localparam logic [7:0] SFR_CPTR_LO = 8'h82; // Code pointer low byte.
	localparam logic [7:0] SFR_CPTR_HI = 8'h83; // Code pointer high byte.
	localparam logic [7:0] SFR_POWER = 8'h87; // Power control.
	localparam logic [7:0] SFR_NVCTL = 8'hB9; // Data store command.
	localparam logic [7:0] SFR_NVDAT = 8'hBC; // Data store data.
	localparam logic [7:0] SFR_REV = 8'hC2; // Silicon revision.
	localparam logic [7:0] SFR_NVADL = 8'hC6; // Data store address low.
	localparam logic [7:0] SFR_NVADH = 8'hC7; // Data store address high.
	localparam logic [7:0] SFR_STATUS = 8'hD0; // Status word.
	localparam logic [7:0] SFR_ACCUM = 8'hE0; // Accumulator.
	localparam logic [7:0] SFR_B = 8'hF0; // Scratch register.
	localparam logic [7:0] SFR_CALL = 8'hF1; // Calibration low.
	localparam logic [7:0] SFR_CALH = 8'hF2; // Calibration high.
	// ----------------------------------------------------------------
	// Reset values and constants.
	// ----------------------------------------------------------------
	localparam logic [7:0] STACK_TOP_RST = 8'h07; // Stack pointer after reset.
	localparam logic [7:0] STATUS_RST = 8'h00; // Status word after reset.
	localparam logic [7:0] POWER_RST = 8'h00; // Power control after reset.
	localparam logic [7:0] POWER_WMASK = 8'hEF; // Bit 4 is reserved.
	localparam logic [7:0] REV_ID = 8'h5A; // Arbitrary value.
	localparam logic [7:0] CAL_FACT_LO = 8'h00; // Factory coefficient low.
	localparam logic [7:0] CAL_FACT_HI = 8'h20; // Factory coefficient high.
	localparam logic [3:0] BIT_BASE_HI = 4'h2; // Bit area starts at 20H.
	localparam int RAM_BYTES = 256; // Internal data RAM.
	localparam int NV_BYTES = 640; // Nonvolatile data store.
	localparam logic [9:0] NV_LAST = 10'h27F; // Highest store address.
	localparam logic [7:0] NV_CMD_READ = 8'h01; // Fetch a byte.
	localparam logic [7:0] NV_CMD_WRITE = 8'h02; // Program a byte.
	// ----------------------------------------------------------------
	// Status word and power control fields.
	// ----------------------------------------------------------------
	localparam int STATUS_CARRY = 7;
	localparam int STATUS_AUX = 6;
	localparam int STATUS_BANK_LO = 3;
	localparam int STATUS_BANK_HI = 4;
	localparam int STATUS_EXCESS = 2;
	localparam int STATUS_PARITY = 0;
	localparam int POWER_RSV = 4;
	// ----------------------------------------------------------------
	// Access carriers.
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DMM_DIRECT = 2'b00,
		DMM_INDIRECT = 2'b01,
		DMM_BIT = 2'b10,
		DMM_WREG = 2'b11
	} dmm_mode_t;
	typedef struct packed {
		logic valid;
		logic we;
		dmm_mode_t mode;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmm_req_t;
	typedef struct packed {
		logic we;
		logic carry;
		logic aux;
		logic excess;
	} dmm_flags_t;
endpackage

// ===== testbench/dmm_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Core-side model: one access per call, launched at a falling edge.
// ------------------------------------------------------------
module dmm_core_model (
	input wire logic clock_i, // Core clock.
	output dmm_pkg::dmm_req_t req_o, // Access request.
	output logic push_o, // Stack push pulse.
	output logic pop_o, // Stack pop pulse.
	output logic [7:0] stack_wdata_o, // Byte to push.
	input wire logic [7:0] rdata_i, // Read answer.
	input wire logic rvalid_i // Answer strobe.
);
	// Quiet until the first call.
	initial begin
		req_o = '0;
		push_o = 1'b0;
		pop_o = 1'b0;
		stack_wdata_o = 8'h00;
	end
	// The rising edge takes the access; the next falling edge drops it and picks up the
	// one-cycle answer. Released fields show inverted values so stale data never matches.
	// Only locations the bench names are touched, unoccupied ones such as 91H included.
	task automatic op(input logic v, input logic we, input logic [1:0] md, input logic [7:0] a,
		input logic [7:0] wd, input logic ps, input logic pp, output logic [7:0] rd,
		output logic rv);
		@(negedge clock_i);
		req_o = '{valid: v, we: we, mode: dmm_pkg::dmm_mode_t'(md), addr: a, wdata: wd};
		push_o = ps;
		pop_o = pp;
		stack_wdata_o = wd;
		@(negedge clock_i);
		rd = rdata_i;
		rv = rvalid_i;
		req_o = '{valid: 1'b0, we: ~we, mode: dmm_pkg::dmm_mode_t'(~md), addr: ~a, wdata: ~wd};
		push_o = 1'b0;
		pop_o = 1'b0;
		stack_wdata_o = ~wd;
	endtask
endmodule

// ===== testbench/internal_data_memory_map_tb_top.sv
`timescale 1ns/1ps
module internal_data_memory_map_tb_top;
	// One table row: access fields, expected read byte and compare mask.
	typedef struct packed {
		logic we;
		logic [1:0] md;
		logic [7:0] a;
		logic [7:0] wd;
		logic [7:0] ex;
		logic [7:0] mk;
	} dmm_row_t;
	logic clock_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic accum_we_i = 1'b0;
	logic [7:0] accum_wdata_i = 8'h00;
	dmm_pkg::dmm_flags_t flags_i = '0;
	logic cptr_we_i = 1'b0;
	logic [15:0] cptr_wdata_i = 16'h0000;
	dmm_pkg::dmm_req_t req;
	logic push, pop, rvalid, rv;
	logic [7:0] swd, rdata, accum, stat, stk, pwr, rd;
	logic [15:0] cptr, cal;
	int n_mismatch = 0;
	int n_compared = 0;
	// Ordinary cases; writes leave ex and mk unused.
	dmm_row_t rows [0:32] = '{
		'{1'h1, 2'h0, 8'h87, 8'hFF, 8'h00, 8'h00}, '{1'h0, 2'h0, 8'h87, 8'h00, 8'hEF, 8'hFF},
		'{1'h0, 2'h0, 8'hC2, 8'h00, dmm_pkg::REV_ID, 8'hFF},
		'{1'h1, 2'h0, 8'hC2, 8'hA0, 8'h00, 8'h00},
		'{1'h0, 2'h0, 8'hC2, 8'h00, dmm_pkg::REV_ID, 8'hFF},
		'{1'h0, 2'h0, 8'hF2, 8'h00, dmm_pkg::CAL_FACT_HI, 8'hFF},
		'{1'h1, 2'h0, 8'hF1, 8'h33, 8'h00, 8'h00}, '{1'h0, 2'h0, 8'hF1, 8'h00, 8'h33, 8'hFF},
		'{1'h1, 2'h0, 8'h91, 8'hAA, 8'h00, 8'h00}, '{1'h0, 2'h0, 8'h91, 8'h00, 8'h00, 8'hFF},
		'{1'h1, 2'h1, 8'hF0, 8'hC3, 8'h00, 8'h00}, '{1'h1, 2'h0, 8'hF0, 8'h77, 8'h00, 8'h00},
		'{1'h0, 2'h1, 8'hF0, 8'h00, 8'hC3, 8'hFF}, '{1'h0, 2'h0, 8'hF0, 8'h00, 8'h77, 8'hFF},
		'{1'h1, 2'h0, 8'h30, 8'h11, 8'h00, 8'h00}, '{1'h0, 2'h1, 8'h30, 8'h00, 8'h11, 8'hFF},
		'{1'h1, 2'h1, 8'h31, 8'h22, 8'h00, 8'h00}, '{1'h0, 2'h0, 8'h31, 8'h00, 8'h22, 8'hFF},
		'{1'h1, 2'h0, 8'h21, 8'h00, 8'h00, 8'h00}, '{1'h1, 2'h2, 8'h09, 8'h01, 8'h00, 8'h00},
		'{1'h0, 2'h0, 8'h21, 8'h00, 8'h02, 8'hFF}, '{1'h0, 2'h2, 8'h09, 8'h00, 8'h01, 8'h01},
		'{1'h1, 2'h0, 8'h82, 8'h34, 8'h00, 8'h00}, '{1'h1, 2'h0, 8'h83, 8'h12, 8'h00, 8'h00},
		'{1'h1, 2'h2, 8'hD5, 8'h01, 8'h00, 8'h00}, '{1'h0, 2'h0, 8'hD0, 8'h00, 8'h20, 8'hFF},
		'{1'h1, 2'h0, 8'hC6, 8'h05, 8'h00, 8'h00}, '{1'h1, 2'h0, 8'hC7, 8'h02, 8'h00, 8'h00},
		'{1'h1, 2'h0, 8'hBC, 8'h9D, 8'h00, 8'h00}, '{1'h1, 2'h0, 8'hB9, 8'h02, 8'h00, 8'h00},
		'{1'h1, 2'h0, 8'hBC, 8'h00, 8'h00, 8'h00}, '{1'h1, 2'h0, 8'hB9, 8'h01, 8'h00, 8'h00},
		'{1'h0, 2'h0, 8'hBC, 8'h00, 8'h9D, 8'hFF}
	};
	always #10 clock_i = ~clock_i;
	dmm_core_model core (.clock_i(clock_i), .req_o(req), .push_o(push), .pop_o(pop),
		.stack_wdata_o(swd), .rdata_i(rdata), .rvalid_i(rvalid));
	dmm_data_memory dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req),
		.push_i(push), .pop_i(pop), .stack_wdata_i(swd), .accum_we_i(accum_we_i),
		.accum_wdata_i(accum_wdata_i), .flags_i(flags_i), .cptr_we_i(cptr_we_i),
		.cptr_wdata_i(cptr_wdata_i), .rdata_o(rdata), .rvalid_o(rvalid), .accumulator_o(accum),
		.program_status_word_o(stat), .stack_top_pointer_o(stk), .power_control_o(pwr),
		.code_pointer_word_o(cptr), .calibration_o(cal));
	// ------------------------------------------------------------
	// Compare and access helpers.
	// ------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
		n_compared++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic chk16(input string nm, input logic [15:0] ex, input logic [15:0] got);
		n_compared++;
		if (got !== ex) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic wr(input logic [1:0] md, input logic [7:0] a, input logic [7:0] d);
		core.op(1'b1, 1'b1, md, a, d, 1'b0, 1'b0, rd, rv);
	endtask
	// A read must answer with a one-cycle strobe and the expected byte.
	task automatic rdc(input string nm, input logic [1:0] md, input logic [7:0] a,
		input logic [7:0] ex);
		core.op(1'b1, 1'b0, md, a, 8'h00, 1'b0, 1'b0, rd, rv);
		chk8({nm, " strobe"}, 8'h01, {7'h00, rv});
		chk8(nm, ex, rd);
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(negedge clock_i);
		chk8("stack top", 8'h07, stk);
		chk8("status", 8'h00, stat);
		chk8("power", 8'h00, pwr);
		chk16("cal", {dmm_pkg::CAL_FACT_HI, dmm_pkg::CAL_FACT_LO}, cal);
		nrst_i = 1'b1;
		// First push after reset lands one above the reset pointer.
		core.op(1'b0, 1'b0, 2'h0, 8'h00, 8'hA5, 1'b1, 1'b0, rd, rv);
		chk8("stack top push", 8'h08, stk);
		rdc("first slot", 2'h1, 8'h08, 8'hA5);
		core.op(1'b0, 1'b0, 2'h0, 8'h00, 8'h00, 1'b0, 1'b1, rd, rv);
		chk8("pop data", 8'hA5, rd);
		chk8("stack top pop", 8'h07, stk);
		wr(2'h0, 8'h81, 8'hFE);
		core.op(1'b0, 1'b0, 2'h0, 8'h00, 8'h3C, 1'b1, 1'b0, rd, rv);
		rdc("deep slot", 2'h1, 8'hFF, 8'h3C);
		foreach (rows[i]) begin
			if (rows[i].we) begin
				wr(rows[i].md, rows[i].a, rows[i].wd);
			end else begin
				// Only the bits under the mask are compared; expected comes from the row.
				core.op(1'b1, 1'b0, rows[i].md, rows[i].a, 8'h00, 1'b0, 1'b0, rd, rv);
				chk8($sformatf("row %0d strobe", i), 8'h01, {7'h00, rv});
				chk8($sformatf("row %0d", i), rows[i].ex & rows[i].mk, rd & rows[i].mk);
			end
		end
		chk16("cptr", 16'h1234, cptr);
		cptr_we_i = 1'b1;
		cptr_wdata_i = 16'hABCD;
		@(negedge clock_i);
		cptr_we_i = 1'b0;
		rdc("cptr low", 2'h0, 8'h82, 8'hCD);
		rdc("cptr high", 2'h0, 8'h83, 8'hAB);
		// Stack moved clear of the banks before they are used.
		wr(2'h0, 8'h81, 8'h60);
		for (int b = 0; b < 4; b++) begin
			wr(2'h0, 8'hD0, {3'h0, b[1:0], 3'h0});
			wr(2'h3, {5'h00, b[2:0]}, 8'h40 + b[7:0]);
			rdc("bank reg", 2'h1, {3'h0, b[1:0], b[2:0]}, 8'h40 + b[7:0]);
		end
		// Arithmetic side: odd accumulator and all three flags; parity follows.
		accum_we_i = 1'b1;
		accum_wdata_i = 8'h07;
		flags_i = '{we: 1'b1, carry: 1'b1, aux: 1'b1, excess: 1'b1};
		@(negedge clock_i);
		accum_we_i = 1'b0;
		flags_i = '0;
		chk8("accum", 8'h07, accum);
		rdc("status flags", 2'h0, 8'hD0, 8'hDD);
		wr(2'h0, 8'hE0, 8'h03);
		wr(2'h0, 8'hD0, 8'h01);
		rdc("status parity", 2'h0, 8'hD0, 8'h00);
		chk8("status out", 8'h00, stat);
		// A frozen clock enable must drop the write.
		ce_i = 1'b0;
		wr(2'h0, 8'hF0, 8'h99);
		ce_i = 1'b1;
		rdc("frozen", 2'h0, 8'hF0, 8'h77);
		// Reset in mid-run restores the pointer and power control.
		wr(2'h0, 8'h87, 8'h0C);
		nrst_i = 1'b0;
		@(negedge clock_i);
		chk8("power rst", 8'h00, pwr);
		chk8("stack top rst", 8'h07, stk);
		chk16("cal rst", {dmm_pkg::CAL_FACT_HI, dmm_pkg::CAL_FACT_LO}, cal);
		nrst_i = 1'b1;
		// The first access after a mid-run release must already be answered.
		rdc("stack top after rst", 2'h0, 8'h81, 8'h07);
		final_report();
	end
endmodule
